// ### logic/acv_pkg.sv
// =====================================================================
// Auxiliary regulator control: shared constants and types
// =====================================================================
package acv_pkg;

    // =================================================================
    // Register map (byte addresses on the Wishbone bus)
    // =================================================================
    localparam logic [7:0] ACV_CTRL_OFS = 8'h00;
    localparam logic [7:0] ACV_STAT_OFS = 8'h04;
    localparam logic [7:0] ACV_MODE_OFS = 8'h08;

    // Control register fields
    localparam int ACV_CTRL_SA_BIT = 0;
    localparam int ACV_CTRL_LS_BIT = 1;
    localparam int ACV_CTRL_STP_BIT = 2;
    localparam int ACV_CTRL_VSEL_BIT = 3;
    localparam int ACV_CTRL_UVKEEP_BIT = 4;

    // Status register fields
    localparam int ACV_STAT_OC_BIT = 0;
    localparam int ACV_STAT_UV_BIT = 1;
    localparam int ACV_STAT_FAIL_BIT = 2;
    localparam int ACV_STAT_ON_BIT = 3;
    localparam int ACV_STAT_LSACT_BIT = 4;
    localparam int ACV_STAT_CFG_LSB = 8;

    // Reset values
    localparam logic [4:0] ACV_CTRL_RST = 5'h00;
    localparam logic [2:0] ACV_FLAGS_RST = 3'h0;

    // Device operating modes, as delivered by the mode controller
    localparam logic [2:0] ACV_MODE_INIT = 3'h0;
    localparam logic [2:0] ACV_MODE_NORMAL = 3'h1;
    localparam logic [2:0] ACV_MODE_STOP = 3'h2;
    localparam logic [2:0] ACV_MODE_SLEEP = 3'h3;
    localparam logic [2:0] ACV_MODE_RESTART = 3'h4;
    localparam logic [2:0] ACV_MODE_FAILSAFE = 3'h5;

    // Number of asynchronous analog comparator inputs
    localparam int ACV_NUM_SENSE = 3;

    // Configuration lock state
    typedef enum logic [2:0] {
        ACV_CFG_NONE = 3'b001,
        ACV_CFG_STANDALONE = 3'b010,
        ACV_CFG_LOADSHARE = 3'b100
    } acv_cfg_t;

endpackage

// ### logic/acv_cfg_if.sv
`timescale 1ns/1ps
// =====================================================================
// Carrier between the register logic and the configuration lock
// =====================================================================
interface acv_cfg_if;
    import acv_pkg::*;
    logic wr;
    logic wr_sa;
    logic wr_ls;
    acv_cfg_t cfg;
    logic fail;

    modport regs (output wr, output wr_sa, output wr_ls, input cfg, input fail);
    modport lock (input wr, input wr_sa, input wr_ls, output cfg, output fail);
endinterface

// ### logic/acv_cfg_lock.sv
`timescale 1ns/1ps
// =====================================================================
// Configuration lock: one-time choice of stand-alone or load sharing
// =====================================================================
module acv_cfg_lock
    import acv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    acv_cfg_if.lock cfg_bus
);

    acv_cfg_t cfg_reg;
    acv_cfg_t cfg_next;
    logic fail_reg;
    logic fail_next;

    // Next lock state from a control write
    always_comb begin
        cfg_next = cfg_reg;
        fail_next = 1'b0;
        if (cfg_bus.wr) begin
            case (cfg_reg)
                ACV_CFG_NONE: begin
                    if (cfg_bus.wr_ls) begin
                        cfg_next = ACV_CFG_LOADSHARE;
                    end else if (cfg_bus.wr_sa) begin
                        cfg_next = ACV_CFG_STANDALONE;
                    end
                end
                ACV_CFG_STANDALONE: begin
                    // Change attempts ignored silently
                    cfg_next = ACV_CFG_STANDALONE;
                end
                ACV_CFG_LOADSHARE: begin
                    // Any change attempt is refused and flagged
                    if (!cfg_bus.wr_ls || cfg_bus.wr_sa) begin
                        fail_next = 1'b1;
                    end
                end
                default: begin
                    cfg_next = ACV_CFG_NONE;
                end
            endcase
        end
    end

    // Lock is cleared only by power-on reset, never by soft reset
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            cfg_reg <= ACV_CFG_NONE;
            fail_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            fail_reg <= fail_next;
        end
    end

    assign cfg_bus.cfg = cfg_reg;
    assign cfg_bus.fail = fail_reg;

endmodule // acv_cfg_lock

// ### logic/acv_aux_ctrl.sv
`timescale 1ns/1ps
// Functional notes
// - Enable written with load-share zero locks stand-alone; later only on/off changes.
// - In locked stand-alone, configuration change writes are ignored without failure flag.
// - Stand-alone overcurrent trip sets overcurrent flag; nothing else happens.
// - Overcurrent flag sticks until cleared; clear works only when condition is gone.
// - Stand-alone monitors output undervoltage and sets the undervoltage status flag.
// - First load-share write locks load sharing; stand-alone enable then ignored.
// - After load sharing locked, change attempts set failure flag, config kept.
// - Stop mode without keep-in-stop disables load sharing, load-share bit stays.
// - Back in Normal mode with load-share set, load sharing resumes automatically.
// - Load sharing runs in Normal and Restart modes, and in Stop when keep-in-stop set.
// - Load sharing configuration neither monitors nor flags output undervoltage.
// - Load sharing configuration switches the regulator off in Fail-Safe mode.
// - Load sharing has no overcurrent limiting and never sets the overcurrent flag.
// - Voltage select acts in stand-alone only, ignored under load sharing.
// - Regulator off below supply undervoltage unless keep-on bit set; auto recovery.
// - Locked configuration survives soft reset, cleared only by power loss.
module acv_aux_ctrl
    import acv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic soft_rst,
    input wire logic [2:0] dev_mode,
    input wire logic supply_uv_pin,
    input wire logic shunt_oc_pin,
    input wire logic aux_uv_pin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic aux_reg_enable,
    output logic aux_load_share_active,
    output logic aux_voltage_select_out,
    output logic aux_oc_limit_enable,
    output logic aux_uv_monitor_enable
);

    // =================================================================
    // Pin synchronisers
    // =================================================================
    logic [ACV_NUM_SENSE-1:0] sense_meta_reg;
    logic [ACV_NUM_SENSE-1:0] sense_sync_reg;
    logic [ACV_NUM_SENSE-1:0] sense_pins;
    logic supply_uv;
    logic shunt_oc;
    logic aux_uv;

    assign sense_pins = {aux_uv_pin, shunt_oc_pin, supply_uv_pin};

    // Two flip-flops per comparator input
    generate
        for (genvar i = 0; i < ACV_NUM_SENSE; i++) begin : g_sync
            always_ff @(posedge sys_clk) begin
                if (srst) begin
                    sense_meta_reg[i] <= 1'b0;
                    sense_sync_reg[i] <= 1'b0;
                end else begin
                    sense_meta_reg[i] <= sense_pins[i];
                    sense_sync_reg[i] <= sense_meta_reg[i];
                end
            end
        end
    endgenerate

    assign supply_uv = sense_sync_reg[0];
    assign shunt_oc = sense_sync_reg[1];
    assign aux_uv = sense_sync_reg[2];

    // =================================================================
    // Wishbone slave
    // =================================================================
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic take;
    logic wr_fire;
    logic wr_ctrl;
    logic wr_stat;
    logic [31:0] rdata_next;

    // New request taken when strobed and not yet acknowledged
    assign take = wb_cyc_i && wb_stb_i && !ack_reg;
    // A write takes effect on the edge that samples ack high
    assign wr_fire = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg && wb_sel_i[0];
    assign wr_ctrl = wr_fire && (wb_adr_i == ACV_CTRL_OFS);
    assign wr_stat = wr_fire && (wb_adr_i == ACV_STAT_OFS);

    // Acknowledge one cycle after the request, drop it the next cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= take;
        end
    end

    // =================================================================
    // Configuration lock
    // =================================================================
    acv_cfg_if cfg_bus ();

    assign cfg_bus.wr = wr_ctrl;
    assign cfg_bus.wr_sa = wb_dat_i[ACV_CTRL_SA_BIT];
    assign cfg_bus.wr_ls = wb_dat_i[ACV_CTRL_LS_BIT];

    acv_cfg_lock u_lock (
        .sys_clk(sys_clk),
        .srst(srst),
        .cfg_bus(cfg_bus)
    );

    logic is_sa;
    logic is_ls;

    assign is_sa = (cfg_bus.cfg == ACV_CFG_STANDALONE);
    assign is_ls = (cfg_bus.cfg == ACV_CFG_LOADSHARE);

    // =================================================================
    // Control bits
    // =================================================================
    logic sa_en_reg;
    logic keep_stop_reg;
    logic vsel_reg;
    logic uv_keep_reg;

    // Stand-alone enable: sets the lock first time, then only on/off
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst) begin
            sa_en_reg <= ACV_CTRL_RST[ACV_CTRL_SA_BIT];
        end else if (wr_ctrl && !is_ls) begin
            if (is_sa || !wb_dat_i[ACV_CTRL_LS_BIT]) begin
                sa_en_reg <= wb_dat_i[ACV_CTRL_SA_BIT];
            end
        end
    end

    // Other control bits, writable in every configuration
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst) begin
            keep_stop_reg <= ACV_CTRL_RST[ACV_CTRL_STP_BIT];
            vsel_reg <= ACV_CTRL_RST[ACV_CTRL_VSEL_BIT];
            uv_keep_reg <= ACV_CTRL_RST[ACV_CTRL_UVKEEP_BIT];
        end else if (wr_ctrl) begin
            keep_stop_reg <= wb_dat_i[ACV_CTRL_STP_BIT];
            vsel_reg <= wb_dat_i[ACV_CTRL_VSEL_BIT];
            uv_keep_reg <= wb_dat_i[ACV_CTRL_UVKEEP_BIT];
        end
    end

    // =================================================================
    // Regulator state by device mode
    // =================================================================
    logic uv_cut;
    logic sa_on_next;
    logic ls_on_next;

    // Supply undervoltage switches off unless the keep-on bit is set
    assign uv_cut = supply_uv && !uv_keep_reg;

    // Stand-alone runs in all modes but init and fail-safe
    always_comb begin
        sa_on_next = 1'b0;
        if (is_sa && sa_en_reg && !uv_cut) begin
            case (dev_mode)
                ACV_MODE_INIT: sa_on_next = 1'b0;
                ACV_MODE_FAILSAFE: sa_on_next = 1'b0;
                default: sa_on_next = 1'b1;
            endcase
        end
    end

    // Load sharing follows the mode; the lock keeps the bit set
    always_comb begin
        ls_on_next = 1'b0;
        if (is_ls && !uv_cut) begin
            case (dev_mode)
                ACV_MODE_NORMAL: ls_on_next = 1'b1;
                ACV_MODE_RESTART: ls_on_next = 1'b1;
                ACV_MODE_STOP: ls_on_next = keep_stop_reg;
                ACV_MODE_FAILSAFE: ls_on_next = 1'b0;
                default: ls_on_next = 1'b0;
            endcase
        end
    end

    // Registered regulator outputs
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            aux_reg_enable <= 1'b0;
            aux_load_share_active <= 1'b0;
            aux_voltage_select_out <= 1'b0;
            aux_oc_limit_enable <= 1'b0;
            aux_uv_monitor_enable <= 1'b0;
        end else begin
            aux_reg_enable <= sa_on_next || ls_on_next;
            aux_load_share_active <= ls_on_next;
            aux_voltage_select_out <= is_sa && vsel_reg;
            aux_oc_limit_enable <= is_sa;
            aux_uv_monitor_enable <= is_sa && sa_on_next;
        end
    end

    // =================================================================
    // Sticky status flags
    // =================================================================
    logic oc_flag_reg;
    logic uv_flag_reg;
    logic fail_flag_reg;
    logic oc_clr;
    logic uv_clr;
    logic fail_clr;

    // Write one to clear
    assign oc_clr = wr_stat && wb_dat_i[ACV_STAT_OC_BIT];
    assign uv_clr = wr_stat && wb_dat_i[ACV_STAT_UV_BIT];
    assign fail_clr = wr_stat && wb_dat_i[ACV_STAT_FAIL_BIT];

    // Overcurrent: set only in stand-alone, clear only once gone
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst) begin
            oc_flag_reg <= ACV_FLAGS_RST[ACV_STAT_OC_BIT];
        end else if (is_sa && shunt_oc) begin
            oc_flag_reg <= 1'b1;
        end else if (oc_clr) begin
            oc_flag_reg <= 1'b0;
        end
    end

    // Undervoltage: monitored only while stand-alone regulator runs
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst) begin
            uv_flag_reg <= ACV_FLAGS_RST[ACV_STAT_UV_BIT];
        end else if (aux_uv_monitor_enable && aux_uv) begin
            uv_flag_reg <= 1'b1;
        end else if (uv_clr) begin
            uv_flag_reg <= 1'b0;
        end
    end

    // Command failure from the lock; set wins over clear
    always_ff @(posedge sys_clk) begin
        if (srst || soft_rst) begin
            fail_flag_reg <= ACV_FLAGS_RST[ACV_STAT_FAIL_BIT];
        end else if (cfg_bus.fail) begin
            fail_flag_reg <= 1'b1;
        end else if (fail_clr) begin
            fail_flag_reg <= 1'b0;
        end
    end

    // =================================================================
    // Read data
    // =================================================================
    // Decode read word; unmapped addresses read zero
    always_comb begin
        rdata_next = 32'h0000_0000;
        case (wb_adr_i)
            ACV_CTRL_OFS: begin
                rdata_next[ACV_CTRL_SA_BIT] = sa_en_reg;
                rdata_next[ACV_CTRL_LS_BIT] = is_ls;
                rdata_next[ACV_CTRL_STP_BIT] = keep_stop_reg;
                rdata_next[ACV_CTRL_VSEL_BIT] = vsel_reg;
                rdata_next[ACV_CTRL_UVKEEP_BIT] = uv_keep_reg;
            end
            ACV_STAT_OFS: begin
                rdata_next[ACV_STAT_OC_BIT] = oc_flag_reg;
                rdata_next[ACV_STAT_UV_BIT] = uv_flag_reg;
                rdata_next[ACV_STAT_FAIL_BIT] = fail_flag_reg;
                rdata_next[ACV_STAT_ON_BIT] = aux_reg_enable;
                rdata_next[ACV_STAT_LSACT_BIT] = aux_load_share_active;
                rdata_next[ACV_STAT_CFG_LSB +: 3] = cfg_bus.cfg;
            end
            ACV_MODE_OFS: begin
                rdata_next[2:0] = dev_mode;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    // Read word captured when the request is taken
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_reg <= 32'h0000_0000;
        end else if (take) begin
            rdata_reg <= rdata_next;
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

endmodule // acv_aux_ctrl

// ### testbench/acv_aux_ctrl_props.sv
`timescale 1ns/1ps
// ====================
// Port checker for the aux regulator control
// ====================
module acv_aux_ctrl_props
    import acv_pkg::*;
(
    input wire logic sys_clk,
    input wire logic srst,
    input wire logic soft_rst,
    input wire logic [2:0] dev_mode,
    input wire logic shunt_oc_pin,
    input wire logic supply_uv_pin,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic aux_load_share_active,
    input wire logic aux_voltage_select_out,
    input wire logic aux_oc_limit_enable,
    input wire logic aux_uv_monitor_enable
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    // Status register read being answered
    logic stat_rd;
    assign stat_rd = wb_ack_o && !wb_we_i && (wb_adr_i == ACV_STAT_OFS);

    // Load sharing seen since power-on; only a locked sharing config raises it
    logic ls_seen;
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            ls_seen <= 1'b0;
        end else if (aux_load_share_active) begin
            ls_seen <= 1'b1;
        end
    end

    // ====================
    // Properties
    // ====================
    property p_ack_once;
        wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    property p_uvmon_sa;
        aux_uv_monitor_enable |-> aux_oc_limit_enable && !aux_load_share_active;
    endproperty
    property p_ls_no_limit;
        aux_load_share_active |-> !aux_oc_limit_enable;
    endproperty
    property p_vsel_sa;
        aux_voltage_select_out |-> aux_oc_limit_enable;
    endproperty
    property p_fs_off;
        dev_mode == ACV_MODE_FAILSAFE |=> !aux_load_share_active;
    endproperty
    property p_sleep_off;
        dev_mode == ACV_MODE_SLEEP |=> !aux_load_share_active;
    endproperty
    property p_ls_resume;
        ls_seen && dev_mode == ACV_MODE_NORMAL && !$past(supply_uv_pin)
            && !$past(supply_uv_pin, 2) && !$past(supply_uv_pin, 3)
            |=> aux_load_share_active;
    endproperty
    property p_ls_no_oc;
        stat_rd && wb_dat_o[ACV_STAT_CFG_LSB + 2] |-> !wb_dat_o[ACV_STAT_OC_BIT];
    endproperty
    property p_oc_sticks;
        $past(shunt_oc_pin, 3) && $past(shunt_oc_pin, 4) && $past(shunt_oc_pin, 5)
            && $past(aux_oc_limit_enable) && $past(aux_oc_limit_enable, 2)
            && !$past(soft_rst) && !$past(soft_rst, 2) && stat_rd |-> wb_dat_o[ACV_STAT_OC_BIT];
    endproperty

    a_ack_once: assert property (p_ack_once) else $error("bus answer not one pulse");
    a_uvmon_sa: assert property (p_uvmon_sa) else $error("uv monitor outside stand-alone");
    a_ls_no_limit: assert property (p_ls_no_limit) else $error("current limit in sharing");
    a_vsel_sa: assert property (p_vsel_sa) else $error("voltage select outside stand-alone");
    a_fs_off: assert property (p_fs_off) else $error("sharing on in fail-safe");
    a_sleep_off: assert property (p_sleep_off) else $error("sharing on in sleep");
    a_ls_resume: assert property (p_ls_resume) else $error("sharing not resumed");
    a_ls_no_oc: assert property (p_ls_no_oc) else $error("overcurrent flag in sharing");
    a_oc_sticks: assert property (p_oc_sticks) else $error("overcurrent flag lost");

    c_ls_stop: cover property (aux_load_share_active && dev_mode == ACV_MODE_STOP);
    c_oc_read: cover property (stat_rd && wb_dat_o[ACV_STAT_OC_BIT]);
    c_fs: cover property (dev_mode == ACV_MODE_FAILSAFE ##1 !aux_load_share_active);
endmodule // acv_aux_ctrl_props

bind acv_aux_ctrl acv_aux_ctrl_props u_props (
    .sys_clk(sys_clk), .srst(srst), .soft_rst(soft_rst), .dev_mode(dev_mode),
    .shunt_oc_pin(shunt_oc_pin), .supply_uv_pin(supply_uv_pin),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .aux_load_share_active(aux_load_share_active),
    .aux_voltage_select_out(aux_voltage_select_out),
    .aux_oc_limit_enable(aux_oc_limit_enable), .aux_uv_monitor_enable(aux_uv_monitor_enable)
);

// ### testbench/acv_aux_ctrl_tb_top.sv
`timescale 1ns/1ps
// ====================
// Self-checking bench for the aux regulator control
// ====================
module acv_aux_ctrl_tb_top;
    import acv_pkg::*;

    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic soft_rst = 1'b0;
    logic [2:0] dev_mode = ACV_MODE_NORMAL;
    logic supply_uv_pin = 1'b0;
    logic shunt_oc_pin = 1'b0;
    logic aux_uv_pin = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o, aux_reg_enable, aux_load_share_active;
    logic aux_voltage_select_out, aux_oc_limit_enable, aux_uv_monitor_enable;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;

    // Clock at 125 MHz
    always #4 sys_clk = ~sys_clk;

    acv_aux_ctrl u_dut (
        .sys_clk(sys_clk), .srst(srst), .soft_rst(soft_rst), .dev_mode(dev_mode),
        .supply_uv_pin(supply_uv_pin), .shunt_oc_pin(shunt_oc_pin), .aux_uv_pin(aux_uv_pin),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .aux_reg_enable(aux_reg_enable), .aux_load_share_active(aux_load_share_active),
        .aux_voltage_select_out(aux_voltage_select_out),
        .aux_oc_limit_enable(aux_oc_limit_enable), .aux_uv_monitor_enable(aux_uv_monitor_enable)
    );

    // ====================
    // Common tasks
    // ====================
    task automatic print_verdict;
        if (error_cnt == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb_xfer(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                           output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= dat;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 16);
        if (wb_ack_o !== 1'b1) error_cnt++;
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] adr, input logic [31:0] dat);
        logic [31:0] d;
        wb_xfer(1'b1, adr, dat, d);
    endtask

    task automatic rd_chk(input logic [7:0] adr, input logic [31:0] mask, input logic [31:0] exp);
        logic [31:0] d;
        wb_xfer(1'b0, adr, 32'h0, d);
        check(d & mask, exp);
    endtask

    task automatic do_reset;
        @(posedge sys_clk);
        srst <= 1'b1;
        dev_mode <= ACV_MODE_NORMAL;
        tick(3);
        srst <= 1'b0;
    endtask

    // ====================
    // Scenarios
    // ====================
    task automatic t_reset;
        rd_chk(ACV_CTRL_OFS, 32'hFFFFFFFF, 32'h0);
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h100);
        rd_chk(ACV_MODE_OFS, 32'hFFFFFFFF, 32'h1);
        rd_chk(8'h0C, 32'hFFFFFFFF, 32'h0);
        wb_sel_i <= 4'hE;
        wr(ACV_CTRL_OFS, 32'h01);
        wb_sel_i <= 4'hF;
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h100);
    endtask

    task automatic t_standalone;
        wr(ACV_CTRL_OFS, 32'h09);
        tick(2);
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h208);
        check(32'(aux_voltage_select_out), 32'h1);
        check(32'(aux_uv_monitor_enable), 32'h1);
        wr(ACV_CTRL_OFS, 32'h02);
        tick(2);
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h200);
        check(32'(aux_load_share_active), 32'h0);
        wr(ACV_CTRL_OFS, 32'h01);
        tick(2);
        aux_uv_pin <= 1'b1;
        tick(6);
        aux_uv_pin <= 1'b0;
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h20A);
        wr(ACV_STAT_OFS, 32'h2);
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h208);
    endtask

    task automatic t_overcurrent;
        shunt_oc_pin <= 1'b1;
        tick(6);
        rd_chk(ACV_STAT_OFS, 32'hFFFFFFFF, 32'h209);
        check(32'(aux_reg_enable), 32'h1);
        wr(ACV_STAT_OFS, 32'h1);
        rd_chk(ACV_STAT_OFS, 32'h1, 32'h1);
        shunt_oc_pin <= 1'b0;
        tick(6);
        rd_chk(ACV_STAT_OFS, 32'h1, 32'h1);
        wr(ACV_STAT_OFS, 32'h1);
        rd_chk(ACV_STAT_OFS, 32'h1, 32'h0);
    endtask

    task automatic t_supply_uv;
        supply_uv_pin <= 1'b1;
        tick(6);
        check(32'(aux_reg_enable), 32'h0);
        wr(ACV_CTRL_OFS, 32'h11);
        tick(2);
        check(32'(aux_reg_enable), 32'h1);
        wr(ACV_CTRL_OFS, 32'h01);
        supply_uv_pin <= 1'b0;
        tick(6);
        check(32'(aux_reg_enable), 32'h1);
    endtask

    // Sharing locked with the same voltage as the main regulator
    task automatic t_loadshare;
        do_reset();
        wr(ACV_CTRL_OFS, 32'h03);
        tick(2);
        rd_chk(ACV_STAT_OFS, 32'h717, 32'h410);
        wr(ACV_CTRL_OFS, 32'h08);
        tick(2);
        check(32'(aux_voltage_select_out), 32'h0);
        rd_chk(ACV_STAT_OFS, 32'h717, 32'h414);
        rd_chk(ACV_CTRL_OFS, 32'h2, 32'h2);
        shunt_oc_pin <= 1'b1;
        aux_uv_pin <= 1'b1;
        tick(6);
        rd_chk(ACV_STAT_OFS, 32'h3, 32'h0);
        shunt_oc_pin <= 1'b0;
        aux_uv_pin <= 1'b0;
    endtask

    // Mode walk; each step allows the one-cycle mode lag
    task automatic t_modes;
        dev_mode <= ACV_MODE_STOP;
        tick(3);
        check(32'(aux_load_share_active), 32'h0);
        rd_chk(ACV_CTRL_OFS, 32'h2, 32'h2);
        dev_mode <= ACV_MODE_NORMAL;
        tick(3);
        check(32'(aux_load_share_active), 32'h1);
        wr(ACV_CTRL_OFS, 32'h06);
        dev_mode <= ACV_MODE_STOP;
        tick(3);
        check(32'(aux_load_share_active), 32'h1);
        dev_mode <= ACV_MODE_SLEEP;
        tick(3);
        check(32'(aux_load_share_active), 32'h0);
        dev_mode <= ACV_MODE_FAILSAFE;
        tick(3);
        check(32'(aux_reg_enable), 32'h0);
        dev_mode <= ACV_MODE_NORMAL;
        tick(3);
    endtask

    task automatic t_soft_reset;
        soft_rst <= 1'b1;
        tick(1);
        soft_rst <= 1'b0;
        tick(2);
        rd_chk(ACV_STAT_OFS, 32'h704, 32'h400);
        wr(ACV_CTRL_OFS, 32'h01);
        tick(2);
        rd_chk(ACV_STAT_OFS, 32'h704, 32'h404);
    endtask

    // Cycle ceiling against a hung run
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end

    // Main sequence
    initial begin
        do_reset();
        t_reset();
        t_standalone();
        t_overcurrent();
        t_supply_uv();
        t_loadshare();
        t_modes();
        t_soft_reset();
        print_verdict();
    end
endmodule // acv_aux_ctrl_tb_top
